// >>> bmt_top.sv
// two-note buzzer tone generator with ping-pong sequencer and power window timer
// assumes synchronous register port strobes and a 125 MHz clock
//
// Summary of operation
// - two note slots A and B each hold their own pitch, on count and rest count.
// - a note's tone runs at the base rate divided by its 12-bit pitch plus one.
// - the base rate is the system clock divided by 32, or by 64 when the base bit is set.
// - each pitch is split over a low byte and the low four bits of a high byte.
// - a note sounds for its 8-bit on count times the time step.
// - the two notes play once in order, or alternate endlessly while loop mode is set.
// - starting either note starts the power window timer in the same time step.
// - when the power window count expires the power window flag is set.
// - the power window timer drives the buzzer power control output.
// - writing one to a go bit starts the note, zero does nothing, completion clears it.
// - if both go bits are set together, note A plays before note B.
// - a finished note sets its end flag when its enable is set; writing zero clears it.
// - a playing bit per note reads high while that note is in progress.
module bmt_top #(
    parameter int STEP_CYCLES = bmt_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire bmt_pkg::bmt_bus_req_s req_i,
    output logic [7:0] rdata_o,
    // buzzer side
    output logic tone_o,
    output logic power_o,
    // interrupt
    output logic irq_o
);

    generate
        if (STEP_CYCLES < 2 || STEP_CYCLES > 131072) begin : g_bad_step
            $error("bmt_top: STEP_CYCLES out of range");
        end
    endgenerate

    localparam logic [16:0] STEP_LAST = 17'(STEP_CYCLES - 1);
    bmt_pkg::bmt_note_s note_a_q, note_b_q;
    logic [7:0] power_window_count_q;
    logic [1:0] time_step_q;
    logic tone_base_select_q;
    logic power_window_irq_enable_q, power_window_irq_flag_q;
    logic note_a_end_irq_enable_q, note_b_end_irq_enable_q;
    logic note_a_end_flag_q, note_b_end_flag_q;
    logic note_a_go_q, note_b_go_q, loop_q;
    bmt_pkg::bmt_state_e state_q, state_d;
    logic [16:0] ms_q;
    logic [2:0] unit_q;
    logic [7:0] phase_q, pow_q;
    logic pow_active_q;
    logic wr_ctrl, wr_step, go_a_wr, go_b_wr, go_any, restart;
    logic ms_tick, unit_tick, phase_end, a_done, b_done, pow_expire;
    logic note_a_playing, note_b_playing, sounding;
    logic [7:0] phase_target;
    logic [2:0] unit_last;
    assign wr_ctrl = req_i.wr && (req_i.addr == bmt_pkg::ADDR_CTRL);
    assign wr_step = req_i.wr && (req_i.addr == bmt_pkg::ADDR_STEP);
    assign go_a_wr = wr_ctrl && req_i.wdata[bmt_pkg::CTRL_A_GO];
    assign go_b_wr = wr_ctrl && req_i.wdata[bmt_pkg::CTRL_B_GO];
    assign go_any = go_a_wr || go_b_wr;
    // the time base only realigns from idle so a running phase keeps its length
    assign restart = go_any && (state_q == bmt_pkg::ST_IDLE);
    // note slot and power window count registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            note_a_q <= '0;
            note_b_q <= '0;
            power_window_count_q <= bmt_pkg::RST_BYTE;
        end else if (req_i.wr) begin
            unique case (req_i.addr)
                bmt_pkg::ADDR_A_PITCH_LO: note_a_q.pitch[7:0] <= req_i.wdata;
                bmt_pkg::ADDR_A_PITCH_HI: note_a_q.pitch[11:8] <= req_i.wdata[3:0];
                bmt_pkg::ADDR_A_ON: note_a_q.on_cnt <= req_i.wdata;
                bmt_pkg::ADDR_A_REST: note_a_q.rest_cnt <= req_i.wdata;
                bmt_pkg::ADDR_B_PITCH_LO: note_b_q.pitch[7:0] <= req_i.wdata;
                bmt_pkg::ADDR_B_PITCH_HI: note_b_q.pitch[11:8] <= req_i.wdata[3:0];
                bmt_pkg::ADDR_B_ON: note_b_q.on_cnt <= req_i.wdata;
                bmt_pkg::ADDR_B_REST: note_b_q.rest_cnt <= req_i.wdata;
                bmt_pkg::ADDR_POW: power_window_count_q <= req_i.wdata;
                default: ;
            endcase
        end
    end
    // step, enable and loop bits
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            time_step_q <= 2'h0;
            tone_base_select_q <= 1'b0;
            power_window_irq_enable_q <= 1'b0;
            note_a_end_irq_enable_q <= 1'b0;
            note_b_end_irq_enable_q <= 1'b0;
            loop_q <= 1'b0;
        end else begin
            if (wr_step) begin
                time_step_q <= req_i.wdata[bmt_pkg::STEP_UNIT_LO +: 2];
                tone_base_select_q <= req_i.wdata[bmt_pkg::STEP_BASE];
                power_window_irq_enable_q <= req_i.wdata[bmt_pkg::STEP_POW_EN];
            end
            if (wr_ctrl) begin
                note_a_end_irq_enable_q <= req_i.wdata[bmt_pkg::CTRL_A_EN];
                note_b_end_irq_enable_q <= req_i.wdata[bmt_pkg::CTRL_B_EN];
                loop_q <= req_i.wdata[bmt_pkg::CTRL_LOOP];
            end
        end
    end
    // time step: a millisecond prescaler then a 1/2/4/8 step counter
    assign ms_tick = (ms_q == STEP_LAST);
    assign unit_last = 3'((4'h1 << time_step_q) - 4'h1);
    assign unit_tick = ms_tick && (unit_q == unit_last);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ms_q <= 17'h00000;
            unit_q <= 3'h0;
        end else if (restart || ms_tick) begin
            ms_q <= 17'h00000;
            unit_q <= (restart || unit_tick) ? 3'h0 : unit_q + 3'h1;
        end else begin
            ms_q <= ms_q + 17'h00001;
        end
    end
    // sequencer
    always_comb begin
        unique case (state_q)
            bmt_pkg::ST_A_ON: phase_target = note_a_q.on_cnt;
            bmt_pkg::ST_A_REST: phase_target = note_a_q.rest_cnt;
            bmt_pkg::ST_B_ON: phase_target = note_b_q.on_cnt;
            bmt_pkg::ST_B_REST: phase_target = note_b_q.rest_cnt;
            default: phase_target = 8'h00;
        endcase
    end

    assign phase_end = (state_q != bmt_pkg::ST_IDLE) && (phase_q == phase_target);
    assign a_done = phase_end && (state_q == bmt_pkg::ST_A_REST);
    assign b_done = phase_end && (state_q == bmt_pkg::ST_B_REST);
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            bmt_pkg::ST_IDLE: begin
                if (note_a_go_q) begin
                    state_d = bmt_pkg::ST_A_ON;
                end else if (note_b_go_q) begin
                    state_d = bmt_pkg::ST_B_ON;
                end
            end
            bmt_pkg::ST_A_ON: if (phase_end) state_d = bmt_pkg::ST_A_REST;
            bmt_pkg::ST_A_REST: begin
                if (phase_end) begin
                    state_d = (note_b_go_q || loop_q) ? bmt_pkg::ST_B_ON : bmt_pkg::ST_IDLE;
                end
            end
            bmt_pkg::ST_B_ON: if (phase_end) state_d = bmt_pkg::ST_B_REST;
            bmt_pkg::ST_B_REST: begin
                if (phase_end) begin
                    state_d = (note_a_go_q || loop_q) ? bmt_pkg::ST_A_ON : bmt_pkg::ST_IDLE;
                end
            end
            default: state_d = bmt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= bmt_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_q <= 8'h00;
        end else if (state_d != state_q) begin
            phase_q <= 8'h00;
        end else if (unit_tick && !phase_end) begin
            phase_q <= phase_q + 8'h01;
        end
    end

    // go bits: set by a one, untouched by a zero, cleared on completion; set wins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            note_a_go_q <= 1'b0;
            note_b_go_q <= 1'b0;
        end else begin
            note_a_go_q <= go_a_wr || (note_a_go_q && !a_done);
            note_b_go_q <= go_b_wr || (note_b_go_q && !b_done);
        end
    end

    // end flags: cleared by writing zero, a completion in the same cycle wins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            note_a_end_flag_q <= 1'b0;
            note_b_end_flag_q <= 1'b0;
        end else begin
            note_a_end_flag_q <= (a_done && note_a_end_irq_enable_q) ||
                (note_a_end_flag_q && !(wr_ctrl && !req_i.wdata[bmt_pkg::CTRL_A_FLAG]));
            note_b_end_flag_q <= (b_done && note_b_end_irq_enable_q) ||
                (note_b_end_flag_q && !(wr_ctrl && !req_i.wdata[bmt_pkg::CTRL_B_FLAG]));
        end
    end

    // power window timer
    assign pow_expire = pow_active_q && !go_any &&
        ((power_window_count_q == 8'h00) || (unit_tick && pow_q == power_window_count_q - 8'h01));
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pow_active_q <= 1'b0;
            pow_q <= 8'h00;
        end else if (go_any) begin
            pow_active_q <= 1'b1;
            pow_q <= 8'h00;
        end else if (pow_expire) begin
            pow_active_q <= 1'b0;
        end else if (pow_active_q && unit_tick) begin
            pow_q <= pow_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_window_irq_flag_q <= 1'b0;
        end else begin
            power_window_irq_flag_q <= pow_expire ||
                (power_window_irq_flag_q && !(wr_step && !req_i.wdata[bmt_pkg::STEP_POW_FLAG]));
        end
    end

    // outputs
    assign note_a_playing = (state_q == bmt_pkg::ST_A_ON) || (state_q == bmt_pkg::ST_A_REST);
    assign note_b_playing = (state_q == bmt_pkg::ST_B_ON) || (state_q == bmt_pkg::ST_B_REST);
    assign sounding = (state_q == bmt_pkg::ST_A_ON) || (state_q == bmt_pkg::ST_B_ON);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            power_o <= pow_active_q;
            irq_o <= (power_window_irq_flag_q && power_window_irq_enable_q) ||
                note_a_end_flag_q || note_b_end_flag_q;
        end
    end

    bmt_tone #(
        .PITCH_W(12)
    ) u_tone (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(sounding),
        .slow_base_i(tone_base_select_q),
        .pitch_i((state_q == bmt_pkg::ST_B_ON) ? note_b_q.pitch : note_a_q.pitch),
        .tone_o(tone_o)
    );
    // read port, data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
        end else if (req_i.rd) begin
            unique case (req_i.addr)
                bmt_pkg::ADDR_A_PITCH_LO: rdata_o <= note_a_q.pitch[7:0];
                bmt_pkg::ADDR_A_PITCH_HI: rdata_o <= {4'h0, note_a_q.pitch[11:8]};
                bmt_pkg::ADDR_A_ON: rdata_o <= note_a_q.on_cnt;
                bmt_pkg::ADDR_A_REST: rdata_o <= note_a_q.rest_cnt;
                bmt_pkg::ADDR_B_PITCH_LO: rdata_o <= note_b_q.pitch[7:0];
                bmt_pkg::ADDR_B_PITCH_HI: rdata_o <= {4'h0, note_b_q.pitch[11:8]};
                bmt_pkg::ADDR_B_ON: rdata_o <= note_b_q.on_cnt;
                bmt_pkg::ADDR_B_REST: rdata_o <= note_b_q.rest_cnt;
                bmt_pkg::ADDR_POW: rdata_o <= power_window_count_q;
                bmt_pkg::ADDR_CTRL: rdata_o <= {1'b0, loop_q, note_b_end_irq_enable_q, note_a_end_irq_enable_q,
                    note_b_end_flag_q, note_a_end_flag_q, note_b_playing, note_a_playing};
                bmt_pkg::ADDR_STEP: rdata_o <= {time_step_q, 1'b0, tone_base_select_q, 2'h0,
                    power_window_irq_enable_q, power_window_irq_flag_q};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end
    // checks
    property p_go_starts;
        @(posedge clk_i) disable iff (!rst_b_i)
        go_a_wr && state_q == bmt_pkg::ST_IDLE |=> ##1 state_q == bmt_pkg::ST_A_ON;
    endproperty
    a_go_starts: assert property (p_go_starts) else $error("note A did not start after go");
    property p_a_first;
        @(posedge clk_i) disable iff (!rst_b_i)
        go_a_wr && go_b_wr && state_q == bmt_pkg::ST_IDLE |=> ##1 note_a_playing && !note_b_playing;
    endproperty
    a_a_first: assert property (p_a_first) else $error("note B played before note A");
    property p_quiet;
        @(posedge clk_i) disable iff (!rst_b_i)
        !sounding |=> !tone_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("tone heard outside an on phase");
    property p_on_bound;
        @(posedge clk_i) disable iff (!rst_b_i)
        state_q == bmt_pkg::ST_A_ON |-> phase_q <= note_a_q.on_cnt;
    endproperty
    a_on_bound: assert property (p_on_bound) else $error("note A on phase overran its count");
    property p_pow_start;
        @(posedge clk_i) disable iff (!rst_b_i)
        go_any |=> ##1 power_o;
    endproperty
    a_pow_start: assert property (p_pow_start) else $error("power output not raised on start");
    property p_pow_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        pow_expire |=> power_window_irq_flag_q && !pow_active_q;
    endproperty
    a_pow_flag: assert property (p_pow_flag) else $error("power window expiry lost");
    property p_irq;
        @(posedge clk_i) disable iff (!rst_b_i)
        power_window_irq_flag_q && !power_window_irq_enable_q && !note_a_end_flag_q && !note_b_end_flag_q
        |=> !irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("masked power window flag raised the interrupt");
    property p_end_flag;
        @(posedge clk_i) disable iff (!rst_b_i)
        a_done && note_a_end_irq_enable_q |=> note_a_end_flag_q && !note_a_go_q;
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("note A end flag not set");
    property p_busy_read;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i.rd && req_i.addr == bmt_pkg::ADDR_CTRL
        |=> rdata_o[1:0] == {$past(note_b_playing), $past(note_a_playing)};
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("playing bits misreported");
    c_a_then_b: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        state_q == bmt_pkg::ST_A_REST ##1 state_q == bmt_pkg::ST_B_ON);
    c_loop: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        loop_q && b_done ##1 state_q == bmt_pkg::ST_A_ON);
    c_pow_expire: cover property (@(posedge clk_i) disable iff (!rst_b_i) pow_expire);
    c_irq: cover property (@(posedge clk_i) disable iff (!rst_b_i) irq_o);

endmodule

// >>> bmt_pkg.sv
// package for the buzzer melody tone generator: register map, field layout,
// reset values, timing constants and carrier types
// assumes a single 125 MHz system clock and an 8-bit register port
package bmt_pkg;

    // register byte addresses
    localparam logic [15:0] ADDR_A_PITCH_LO = 16'hA040;
    localparam logic [15:0] ADDR_A_PITCH_HI = 16'hA041;
    localparam logic [15:0] ADDR_A_ON = 16'hA042;
    localparam logic [15:0] ADDR_A_REST = 16'hA043;
    localparam logic [15:0] ADDR_B_PITCH_LO = 16'hA044;
    localparam logic [15:0] ADDR_B_PITCH_HI = 16'hA045;
    localparam logic [15:0] ADDR_B_ON = 16'hA046;
    localparam logic [15:0] ADDR_B_REST = 16'hA047;
    localparam logic [15:0] ADDR_CTRL = 16'hA048;
    localparam logic [15:0] ADDR_POW = 16'hA049;
    localparam logic [15:0] ADDR_STEP = 16'hA04A;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;

    // note_control fields
    localparam int CTRL_A_GO = 0;
    localparam int CTRL_B_GO = 1;
    localparam int CTRL_A_FLAG = 2;
    localparam int CTRL_B_FLAG = 3;
    localparam int CTRL_A_EN = 4;
    localparam int CTRL_B_EN = 5;
    localparam int CTRL_LOOP = 6;

    // time_unit_control fields
    localparam int STEP_POW_FLAG = 0;
    localparam int STEP_POW_EN = 1;
    localparam int STEP_BASE = 4;
    localparam int STEP_UNIT_LO = 6;

    // tone base prescale
    localparam logic [5:0] BASE_FAST_LAST = 6'h1F;
    localparam logic [5:0] BASE_SLOW_LAST = 6'h3F;

    // time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int TIME_STEP_NS = 1000000;
    localparam int STEP_CYCLES = TIME_STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_A_ON = 3'b001,
        ST_A_REST = 3'b010,
        ST_B_ON = 3'b011,
        ST_B_REST = 3'b100
    } bmt_state_e;

    typedef struct packed {
        logic [11:0] pitch;
        logic [7:0] on_cnt;
        logic [7:0] rest_cnt;
    } bmt_note_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bmt_bus_req_s;

endpackage

// >>> bmt_tone.sv
// tone divider: base prescale of 32 or 64, then a divide by pitch plus one
// assumes run_i is held steady for the whole note
module bmt_tone #(
    parameter int PITCH_W = 12
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic run_i,
    input wire logic slow_base_i,
    input wire logic [PITCH_W-1:0] pitch_i,
    // tone
    output logic tone_o
);

    generate
        if (PITCH_W < 1) begin : g_bad_width
            $error("bmt_tone: PITCH_W must be at least 1");
        end
    endgenerate

    logic [5:0] pre_q;
    logic [PITCH_W-1:0] per_q;
    logic base_tick;
    logic [5:0] pre_last;

    assign pre_last = slow_base_i ? bmt_pkg::BASE_SLOW_LAST : bmt_pkg::BASE_FAST_LAST;
    assign base_tick = run_i && (pre_q == pre_last);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q <= 6'h00;
        end else if (!run_i || base_tick) begin
            pre_q <= 6'h00;
        end else begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // one tone period spans pitch plus one base ticks
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            per_q <= '0;
        end else if (!run_i) begin
            per_q <= '0;
        end else if (base_tick) begin
            per_q <= (per_q >= pitch_i) ? '0 : per_q + 1'b1;
        end
    end

    // high for the first half; a pitch of zero gives a steady high level
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tone_o <= 1'b0;
        end else begin
            tone_o <= run_i && (per_q <= (pitch_i >> 1));
        end
    end

    property p_pre_bound;
        @(posedge clk_i) disable iff (!rst_b_i)
        (pre_q == bmt_pkg::BASE_FAST_LAST) && !slow_base_i && run_i |=> pre_q == 6'h00;
    endproperty
    a_pre_bound: assert property (p_pre_bound) else $error("fast base prescale did not wrap at 32");

endmodule

// >>> bmt_buzzer_model.sv
// buzzer element and power switch model: measures tone edges and power windows
// assumes tone_i and power_i are registered outputs of the generator
module bmt_buzzer_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // buzzer side
    input wire logic tone_i,
    input wire logic power_i,
    // measurements
    output int rise_cnt,
    output int last_period,
    output int pow_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    int last_rise;
    int pow_start;
    logic tone_q;
    logic power_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cyc <= 0;
            last_rise <= 0;
            pow_start <= 0;
            tone_q <= 1'b0;
            power_q <= 1'b0;
            rise_cnt <= 0;
            last_period <= 0;
            pow_len <= 0;
        end else begin
            cyc <= cyc + 1;
            tone_q <= tone_i;
            power_q <= power_i;
            // the element only sees edges, so level glitches count as tones
            if (tone_i && !tone_q) begin
                rise_cnt <= rise_cnt + 1;
                last_period <= cyc - last_rise;
                last_rise <= cyc;
            end
            if (power_i && !power_q) begin
                pow_start <= cyc;
            end
            if (!power_i && power_q) begin
                pow_len <= cyc - pow_start;
            end
        end
    end
endmodule

// >>> bmt_top_tb.sv
// self-checking bench for the buzzer tone generator
// assumes a shortened time step; only the power window expectations scale from STEP
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module bmt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 20;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    bmt_pkg::bmt_bus_req_s req_i = '0;
    logic [7:0] rdata_o;
    logic tone_o;
    logic power_o;
    logic irq_o;
    int fail_count = 0;
    int comparisons = 0;
    int rise_cnt;
    int last_period;
    int pow_len;
    int r0;
    logic [7:0] d;
    bmt_top #(.STEP_CYCLES(STEP)) bmt_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req_i),
        .rdata_o(rdata_o), .tone_o(tone_o), .power_o(power_o), .irq_o(irq_o));
    bmt_buzzer_model bmt_buzzer_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .tone_i(tone_o),
        .power_i(power_o), .rise_cnt(rise_cnt), .last_period(last_period), .pow_len(pow_len));
    initial forever #4 clk_i = ~clk_i;
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        req_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        req_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk_i);
        req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        req_i.rd <= 1'b0;
        #1;
        d = rdata_o;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 12; i++) begin
            rd(16'hA040 + 16'(i));
            `CHK("reset reg", 8'h00, d)
        end
        `CHK("reset outs", 3'b000, {tone_o, power_o, irq_o})
        $display("test reset done");
    endtask
    task automatic t_tone();
        wr(bmt_pkg::ADDR_A_PITCH_LO, 8'h01);
        wr(bmt_pkg::ADDR_A_PITCH_HI, 8'hF0);
        rd(bmt_pkg::ADDR_A_PITCH_HI);
        `CHK("pitch hi", 8'h00, d)
        wr(bmt_pkg::ADDR_A_ON, 8'h14);
        wr(bmt_pkg::ADDR_A_REST, 8'h01);
        wr(bmt_pkg::ADDR_CTRL, 8'h01);
        r0 = rise_cnt;
        idle(450);
        `CHK("period /32", 64, last_period)
        `CHK("rises", 1'b1, (rise_cnt - r0 >= 5 && rise_cnt - r0 <= 7))
        wr(bmt_pkg::ADDR_B_PITCH_LO, 8'h01);
        wr(bmt_pkg::ADDR_B_ON, 8'h14);
        wr(bmt_pkg::ADDR_B_REST, 8'h01);
        wr(bmt_pkg::ADDR_STEP, 8'h10);
        wr(bmt_pkg::ADDR_CTRL, 8'h02);
        idle(450);
        `CHK("period /64", 128, last_period)
        $display("test tone done");
    endtask
    task automatic t_both();
        wr(bmt_pkg::ADDR_A_ON, 8'h02);
        wr(bmt_pkg::ADDR_A_REST, 8'h03);
        wr(bmt_pkg::ADDR_B_ON, 8'h02);
        wr(bmt_pkg::ADDR_CTRL, 8'h33);
        idle(3);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("a first", 8'h31, d)
        // a zero go write while A plays must leave the queued B in place
        wr(bmt_pkg::ADDR_CTRL, 8'h30);
        idle(45);
        `CHK("rest silent", 1'b0, tone_o)
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("a in rest", 8'h31, d)
        idle(75);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("then b", 8'h36, d)
        wr(bmt_pkg::ADDR_CTRL, 8'h34);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("go zero", 8'h36, d)
        idle(100);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("both flags", 8'h3C, d)
        `CHK("note irq", 1'b1, irq_o)
        wr(bmt_pkg::ADDR_CTRL, 8'h30);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("flags clear", 8'h30, d)
        idle(2);
        `CHK("irq off", 1'b0, irq_o)
        $display("test both done");
    endtask
    task automatic t_pow();
        int e;
        wr(bmt_pkg::ADDR_A_ON, 8'h01);
        wr(bmt_pkg::ADDR_A_REST, 8'h00);
        wr(bmt_pkg::ADDR_POW, 8'h03);
        for (int u = 0; u < 4; u++) begin
            e = 3 * (STEP << u);
            wr(bmt_pkg::ADDR_STEP, 8'(u << 6));
            wr(bmt_pkg::ADDR_CTRL, 8'h01);
            idle(e + 40);
            `CHK("pow len", 1'b1, (pow_len >= e - 2 && pow_len <= e + 4))
        end
        rd(bmt_pkg::ADDR_STEP);
        `CHK("pow flag", 8'hC1, d)
        `CHK("masked", 1'b0, irq_o)
        wr(bmt_pkg::ADDR_STEP, 8'hC3);
        idle(3);
        `CHK("pow irq", 1'b1, irq_o)
        wr(bmt_pkg::ADDR_STEP, 8'hC2);
        idle(3);
        `CHK("pow irq off", 1'b0, irq_o)
        rd(bmt_pkg::ADDR_STEP);
        `CHK("pow clr", 8'hC2, d)
        $display("test power done");
    endtask
    task automatic t_loop();
        wr(bmt_pkg::ADDR_STEP, 8'h00);
        wr(bmt_pkg::ADDR_A_ON, 8'h02);
        wr(bmt_pkg::ADDR_B_REST, 8'h00);
        wr(bmt_pkg::ADDR_CTRL, 8'h41);
        idle(3);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("loop a", 8'h41, d & 8'h43)
        idle(50);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("loop b", 8'h42, d & 8'h43)
        idle(40);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("loop a again", 8'h41, d & 8'h43)
        wr(bmt_pkg::ADDR_CTRL, 8'h00);
        idle(200);
        rd(bmt_pkg::ADDR_CTRL);
        `CHK("loop stop", 8'h00, d)
        $display("test loop done");
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_tone();
        t_both();
        t_pow();
        t_loop();
        finish_test();
    end
endmodule
